// [verilog/sss_pkg.sv]
// Package for the two-channel three-wire serial port: map, fields, state
`default_nettype none
package sss_pkg;
    // Channel count and bus address width
    localparam int NCH = 2;
    localparam int ADDR_W = 20;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CTRL1 = 16'hff91;
    localparam logic [15:0] IDX_CTRL2 = 16'hff92;
    localparam logic [15:0] IDX_SHIFT1 = 16'hff93;
    localparam logic [15:0] IDX_SHIFT2 = 16'hff94;
    localparam logic [15:0] IDX_STAT = 16'hff95;
    localparam logic [15:0] IDX_IEN = 16'hff96;
    localparam logic [15:0] IDX_ICLR = 16'hff97;
    localparam logic [15:0] IDX_BIT1 = 16'hff98;
    localparam logic [15:0] IDX_BIT2 = 16'hff99;
    // Internal register identifiers after decode
    localparam logic [3:0] REG_CTRL1 = 4'h0;
    localparam logic [3:0] REG_SHIFT1 = 4'h2;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_IEN = 4'h5;
    localparam logic [3:0] REG_ICLR = 4'h6;
    localparam logic [3:0] REG_BIT1 = 4'h7;
    localparam logic [3:0] REG_NONE = 4'hf;
    // Control register fields
    localparam int EN_BIT = 7;
    localparam int MODE_BIT = 2;
    localparam int SEL_HI = 1;
    localparam int SEL_LO = 0;
    localparam logic [7:0] CTRL_MASK = 8'h87;
    // Single-bit access register fields
    localparam int BITIDX_HI = 2;
    localparam int BITVAL_POS = 8;
    // Values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    // Clock select codes
    localparam logic [1:0] SEL_EXT = 2'h0;
    localparam logic [1:0] SEL_TIMER = 2'h1;
    localparam logic [1:0] SEL_DIV8 = 2'h2;
    localparam logic [1:0] SEL_DIV16 = 2'h3;
    // Internal clock ratios and half-period terminal counts
    localparam int DIV8_RATIO = 8;
    localparam int DIV16_RATIO = 16;
    localparam logic [3:0] DIV8_LAST = 4'(DIV8_RATIO / 2 - 1);
    localparam logic [3:0] DIV16_LAST = 4'(DIV16_RATIO / 2 - 1);
    // Index of the last bit of a byte
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Whole state of the block
    typedef struct packed {
        logic [NCH-1:0][7:0] ctrl;
        logic [NCH-1:0][7:0] shreg;
        logic [NCH-1:0][2:0] cnt;
        logic [NCH-1:0][3:0] div;
        logic [NCH-1:0] busy;
        logic [NCH-1:0] sck_int;
        logic [NCH-1:0] sck_oe;
        logic [NCH-1:0] so;
        logic [NCH-1:0] so_oe;
        logic [NCH-1:0][2:0] sck_sync;
        logic [NCH-1:0][2:0] si_sync;
        logic [NCH-1:0] sck_lvl;
        logic [NCH-1:0] si_lvl;
        logic [2:0] tm_sync;
        logic tm_lvl;
        logic [NCH-1:0] irq_stat;
        logic [NCH-1:0] irq_en;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sss_state_s;
endpackage
`default_nettype wire

// [verilog/sss_top.sv]
// Two-channel three-wire synchronous serial port with APB registers
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: Eight bits per transfer, MSB first
// R2: Shift out and in during same periods
// R3: Reset clears both shift registers
// R4: Reset clears control: disabled, external clock
// R5: Shift register byte only; control bit or byte
// R6: Enable bit lets shift access start transfer
// R7: Disabled: no shifting, counter cleared, pins free
// R8: Transmit/receive mode: write starts, normal output
// R9: Receive-only mode: read starts, output low
// R10: Clock select: pin, timer, div8, div16
// R11: Falling serial clock edge shifts output latch
// R12: Rising serial clock edge samples input
// R13: Stop after eight bits, set done flag
// R14: Start only enabled, clock stopped or high
// R15: Write while disabled then enable: no start
// R16: Software avoids shift register during transfer
// R17: Control bits six to three read zero
// R18: Clock line idles high, driver per select
module sss_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sss_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial clock pins, one per channel
    input wire logic [sss_pkg::NCH-1:0] sck_in,
    output logic [sss_pkg::NCH-1:0] sck_out,
    output logic [sss_pkg::NCH-1:0] sck_oe,
    // Serial data pins
    input wire logic [sss_pkg::NCH-1:0] si_in,
    output logic [sss_pkg::NCH-1:0] so_out,
    output logic [sss_pkg::NCH-1:0] so_oe,
    // Timer output used as a shift clock source
    input wire logic timer_two,
    // Transfer-done interrupt
    output logic irq
);
    import sss_pkg::*;

    // Current and next state
    sss_state_s st;
    sss_state_s nx;
    // Bus helpers
    logic acc;
    logic commit;
    logic [3:0] rid;
    logic [NCH-1:0] clr;
    logic tm_rise;
    // Per-channel event helpers
    logic [NCH-1:0] trig_wr;
    logic [NCH-1:0] trig_rd;
    logic [NCH-1:0] can_go;
    logic [NCH-1:0] fall_v;
    logic [NCH-1:0] rise_v;
    logic [NCH-1:0] done_v;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Address decode, used for both read and write
    function automatic logic [3:0] reg_id(input logic [ADDR_W-1:0] a);
        reg_id = REG_NONE;
        if (a == {2'b00, IDX_CTRL1, 2'b00}) begin
            reg_id = REG_CTRL1;
        end else if (a == {2'b00, IDX_CTRL2, 2'b00}) begin
            reg_id = REG_CTRL1 + 4'h1;
        end else if (a == {2'b00, IDX_SHIFT1, 2'b00}) begin
            reg_id = REG_SHIFT1;
        end else if (a == {2'b00, IDX_SHIFT2, 2'b00}) begin
            reg_id = REG_SHIFT1 + 4'h1;
        end else if (a == {2'b00, IDX_STAT, 2'b00}) begin
            reg_id = REG_STAT;
        end else if (a == {2'b00, IDX_IEN, 2'b00}) begin
            reg_id = REG_IEN;
        end else if (a == {2'b00, IDX_ICLR, 2'b00}) begin
            reg_id = REG_ICLR;
        end else if (a == {2'b00, IDX_BIT1, 2'b00}) begin
            reg_id = REG_BIT1;
        end else if (a == {2'b00, IDX_BIT2, 2'b00}) begin
            reg_id = REG_BIT1 + 4'h1;
        end
    endfunction

    // Read value for a decoded register
    function automatic logic [7:0] rd_val(input logic [3:0] id, input sss_state_s s);
        rd_val = 8'h00;
        if (id == REG_CTRL1 || id == REG_CTRL1 + 4'h1) begin
            rd_val = s.ctrl[id[0]] & CTRL_MASK;
        end else if (id == REG_SHIFT1 || id == REG_SHIFT1 + 4'h1) begin
            rd_val = s.shreg[id[0]];
        end else if (id == REG_STAT) begin
            rd_val = {{(8 - NCH){1'b0}}, s.irq_stat};
        end else if (id == REG_IEN) begin
            rd_val = {{(8 - NCH){1'b0}}, s.irq_en};
        end
    endfunction

    // Next-state logic for bus, synchronisers and both channels
    always_comb begin
        nx = st;
        trig_wr = '0;
        trig_rd = '0;
        can_go = '0;
        fall_v = '0;
        rise_v = '0;
        done_v = '0;
        acc = psel & penable;
        rid = reg_id(paddr);
        // Effects land on the edge where pready is sampled high
        commit = acc & st.pready & ~st.pslverr;
        clr = '0;
        // Timer input: three stages, level taken when stages agree
        nx.tm_sync = {st.tm_sync[1:0], timer_two};
        if (st.tm_sync[1] == st.tm_sync[2]) begin
            nx.tm_lvl = st.tm_sync[1];
        end
        tm_rise = nx.tm_lvl & ~st.tm_lvl;
        // APB: answer one cycle into the access phase
        if (acc && !st.pready) begin
            nx.pready = 1'b1;
            // Shift register takes only a full low-byte write
            nx.pslverr = (rid == REG_NONE) || (pwrite && !pstrb[0] &&
                (rid == REG_SHIFT1 || rid == REG_SHIFT1 + 4'h1)); // R5
            nx.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val(rid, st)};
        end else if (acc) begin
            // Completion edge
            nx.pready = 1'b0;
            nx.pslverr = 1'b0;
        end
        // Interrupt enable and write-one-to-clear
        if (commit && pwrite && rid == REG_IEN) begin
            nx.irq_en = pwdata[NCH-1:0];
        end
        if (commit && pwrite && rid == REG_ICLR) begin
            clr = pwdata[NCH-1:0];
        end
        // Channel engines
        for (int ch = 0; ch < NCH; ch++) begin
            // Pin synchronisers
            nx.sck_sync[ch] = {st.sck_sync[ch][1:0], sck_in[ch]};
            if (st.sck_sync[ch][1] == st.sck_sync[ch][2]) begin
                nx.sck_lvl[ch] = st.sck_sync[ch][1];
            end
            nx.si_sync[ch] = {st.si_sync[ch][1:0], si_in[ch]};
            if (st.si_sync[ch][1] == st.si_sync[ch][2]) begin
                nx.si_lvl[ch] = st.si_sync[ch][1];
            end
            // Shift clock edges from the selected source
            if (st.ctrl[ch][SEL_HI:SEL_LO] != SEL_EXT) begin
                if (st.busy[ch]) begin
                    // Timer rising edges or divided system clock toggle the line
                    if (st.ctrl[ch][SEL_HI:SEL_LO] == SEL_TIMER) begin // R10
                        if (tm_rise) begin
                            nx.sck_int[ch] = ~st.sck_int[ch];
                        end
                    end else if ((st.ctrl[ch][SEL_HI:SEL_LO] == SEL_DIV8 &&
                                  st.div[ch] == DIV8_LAST) ||
                                 (st.ctrl[ch][SEL_HI:SEL_LO] == SEL_DIV16 &&
                                  st.div[ch] == DIV16_LAST)) begin // R10
                        nx.div[ch] = 4'h0;
                        nx.sck_int[ch] = ~st.sck_int[ch];
                    end else begin
                        nx.div[ch] = st.div[ch] + 4'h1;
                    end
                    fall_v[ch] = st.sck_int[ch] & ~nx.sck_int[ch];
                    rise_v[ch] = ~st.sck_int[ch] & nx.sck_int[ch];
                end else begin
                    // Internal clock rests high between bytes
                    nx.div[ch] = 4'h0;
                    nx.sck_int[ch] = 1'b1; // R18
                end
            end else begin
                // External clock from the far party
                nx.sck_int[ch] = 1'b1;
                fall_v[ch] = st.busy[ch] & st.sck_lvl[ch] & ~nx.sck_lvl[ch];
                rise_v[ch] = st.busy[ch] & ~st.sck_lvl[ch] & nx.sck_lvl[ch];
            end
            // Falling edge: next bit into the output latch
            if (fall_v[ch]) begin
                nx.so[ch] = st.shreg[ch][7]; // R11 R1
            end
            // Rising edge: sample input, shift, count
            if (rise_v[ch]) begin
                // Take the level accepted at this very edge; the old one is a bit late
                nx.shreg[ch] = {st.shreg[ch][6:0], nx.si_lvl[ch]}; // R12 R2
                if (st.cnt[ch] == LAST_BIT) begin
                    // Eighth bit: stop and flag
                    nx.cnt[ch] = 3'h0;
                    nx.busy[ch] = 1'b0; // R13
                    done_v[ch] = 1'b1; // R13
                end else begin
                    nx.cnt[ch] = st.cnt[ch] + 3'h1; // R1
                end
            end
            // Start condition: enabled, idle, clock stopped or high
            can_go[ch] = st.ctrl[ch][EN_BIT] && !st.busy[ch] &&
                (st.ctrl[ch][SEL_HI:SEL_LO] != SEL_EXT || st.sck_lvl[ch]); // R14 R6
            trig_wr[ch] = commit && pwrite && rid == REG_SHIFT1 + 4'(ch);
            trig_rd[ch] = commit && !pwrite && rid == REG_SHIFT1 + 4'(ch);
            // Write loads data; starts only in transmit/receive mode
            if (trig_wr[ch]) begin
                nx.shreg[ch] = pwdata[7:0];
                if (can_go[ch] && !st.ctrl[ch][MODE_BIT]) begin // R8 R15
                    nx.busy[ch] = 1'b1;
                    nx.cnt[ch] = 3'h0;
                    nx.div[ch] = 4'h0;
                end
            end
            // Read starts in receive-only mode
            if (trig_rd[ch] && can_go[ch] && st.ctrl[ch][MODE_BIT]) begin // R9
                nx.busy[ch] = 1'b1;
                nx.cnt[ch] = 3'h0;
                nx.div[ch] = 4'h0;
            end
            // Disabled channel: engine stopped, counter cleared
            if (!st.ctrl[ch][EN_BIT]) begin
                nx.busy[ch] = 1'b0; // R7
                nx.cnt[ch] = 3'h0; // R7
                nx.div[ch] = 4'h0;
            end
            // Receive-only mode holds the output low
            if (st.ctrl[ch][MODE_BIT]) begin
                nx.so[ch] = 1'b0; // R9
            end
            // Pin drivers: released to port use when disabled
            nx.sck_oe[ch] = st.ctrl[ch][EN_BIT] &&
                st.ctrl[ch][SEL_HI:SEL_LO] != SEL_EXT; // R18 R7
            nx.so_oe[ch] = st.ctrl[ch][EN_BIT]; // R7
            // Control writes: byte, or single bit; bits six to three stay zero
            if (commit && pwrite && rid == REG_CTRL1 + 4'(ch)) begin
                nx.ctrl[ch] = pwdata[7:0] & CTRL_MASK; // R5 R17
            end
            if (commit && pwrite && rid == REG_BIT1 + 4'(ch) &&
                CTRL_MASK[pwdata[BITIDX_HI:0]]) begin
                nx.ctrl[ch][pwdata[BITIDX_HI:0]] = pwdata[BITVAL_POS]; // R5 R17
            end
        end
        // Sticky done flags: a new event beats a clear
        nx.irq_stat = (st.irq_stat & ~clr) | done_v; // R13
        nx.irq = |(nx.irq_stat & nx.irq_en);
    end

    // State register; reset clears control and shift registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.ctrl <= {NCH{CTRL_RESET}}; // R4
            st.shreg <= {NCH{SHIFT_RESET}}; // R3
            st.sck_int <= '1;
            st.sck_lvl <= '1;
            // Clock pin rests high; match it so no false edge follows reset
            st.sck_sync <= '1;
        end else begin
            st <= nx;
        end
    end

    // Outputs straight from state flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign sck_out = st.sck_int;
    assign sck_oe = st.sck_oe;
    assign so_out = st.so;
    assign so_oe = st.so_oe;
    assign irq = st.irq;

    // Per-channel checks
    for (genvar g = 0; g < NCH; g++) begin : g_chk
        a_reserved_zero: assert property (st.ctrl[g][6:3] == 4'h0) // R17
            else $error("reserved control bits set");
        a_disabled_idle: assert property (!st.ctrl[g][EN_BIT] |=> // R7
            !st.busy[g] && st.cnt[g] == 3'h0)
            else $error("disabled channel not idle");
        a_rxonly_low: assert property (st.ctrl[g][EN_BIT] && st.ctrl[g][MODE_BIT] // R9
            |=> !so_out[g])
            else $error("serial output not low in receive-only mode");
        a_done_flag: assert property ($fell(st.busy[g]) && st.ctrl[g][EN_BIT] // R13
            |-> $past(st.cnt[g]) == LAST_BIT && st.irq_stat[g])
            else $error("transfer ended without eight bits and flag");
        a_write_start: assert property (trig_wr[g] && can_go[g] && // R8
            !st.ctrl[g][MODE_BIT] |=> st.busy[g])
            else $error("write did not start transfer");
        a_no_start_off: assert property (trig_wr[g] && !st.ctrl[g][EN_BIT] // R15
            |=> !st.busy[g] [*2])
            else $error("transfer started while disabled");
        a_idle_high: assert property (st.ctrl[g][EN_BIT] && !st.busy[g] && // R18
            st.ctrl[g][SEL_HI:SEL_LO] != SEL_EXT |=> sck_out[g])
            else $error("internal clock not idle high");
        a_msb_first: assert property (fall_v[g] && !st.ctrl[g][MODE_BIT] // R11
            |=> so_out[g] == $past(st.shreg[g][7]))
            else $error("output latch not loaded with top bit");
        a_byte_only: assert property (acc && !st.pready && pwrite && !pstrb[0] && // R5
            rid == REG_SHIFT1 + 4'(g) |=> pready && pslverr)
            else $error("partial shift register write not refused");
    end
endmodule
`default_nettype wire

// [test/sss_periph.sv]
// Behavioural far-side peripheral for one serial channel
`timescale 1ns/1ps
`default_nettype none
module sss_periph (
    // Bench clock
    input wire logic pclk,
    // Serial wires as seen on the board
    input wire logic sck,
    input wire logic so,
    output logic si,
    output logic sck_ext,
    // Bench control
    input wire logic load,
    input wire logic go,
    input wire logic [7:0] tx,
    output logic [7:0] rx
);
    logic [2:0] fcnt = 3'h7; // Next bit to launch
    logic [3:0] rcnt = 4'h8; // Bits taken in this frame
    logic d = 1'b0; // Launched data bit
    logic idl = 1'b0; // Junk shown while the line is released
    logic [4:0] nhalf = 5'h0; // Clock half periods still to make
    logic [2:0] hc = 3'h0; // Cycles within one half period
    wire act = (rcnt != 4'h8); // Inside a frame

    // Released data line changes every cycle, so no stale bit survives
    assign si = act ? d : idl;
    initial sck_ext = 1'b1;
    initial rx = 8'h00;

    // Launch the next bit on each falling clock, MSB first
    always @(negedge sck or posedge load) begin
        if (load) begin
            fcnt <= 3'h7;
        end else if (act) begin
            d <= tx[fcnt];
            fcnt <= fcnt - 3'h1;
        end
    end

    // Take the device's bit on each rising clock; frame ends after eight
    always @(posedge sck or posedge load) begin
        if (load) begin
            rcnt <= 4'h0;
        end else if (act) begin
            rx <= {rx[6:0], so};
            rcnt <= rcnt + 4'h1;
        end
    end

    // External clock: eight periods on request, idling high between bytes
    always @(posedge pclk) begin
        idl <= ~idl;
        if (go) begin
            nhalf <= 5'h10;
        end else if (nhalf != 5'h0) begin
            hc <= hc + 3'h1;
            if (hc == 3'h7) begin
                sck_ext <= ~sck_ext;
                nhalf <= nhalf - 5'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the two-channel three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sss_pkg::*;
    // One bus transfer and what it should give
    typedef struct packed {
        logic wr;
        logic [15:0] idx;
        logic [31:0] d;
        logic [31:0] e;
        logic er;
    } sss_row_s;
    // Clock, reset, bus and interrupt
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, timer_two;
    logic [ADDR_W-1:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd;
    // Pins and partner controls
    logic [NCH-1:0] sck_out, sck_oe, so_out, so_oe, si, sck_ext, sck_w, load, go;
    logic [NCH-1:0][7:0] ptx, prx;
    int num_errors, tests_run, tcnt;
    // Register traffic: reset values, fields, bit writes, map holes
    sss_row_s rows [14] = '{
        '{0, IDX_CTRL1, 0, 0, 0},
        '{0, IDX_CTRL2, 0, 0, 0},
        '{0, IDX_SHIFT1, 0, 0, 0},
        '{0, IDX_SHIFT2, 0, 0, 0},
        '{1, IDX_CTRL2, 32'h0000_00ff, 0, 0},
        '{0, IDX_CTRL2, 0, 32'h0000_0087, 0},
        '{1, IDX_CTRL2, 0, 0, 0},
        '{1, IDX_BIT1, 32'h0000_0107, 0, 0},
        '{1, IDX_BIT1, 32'h0000_0105, 0, 0},
        '{0, IDX_CTRL1, 0, 32'h0000_0080, 0},
        '{1, IDX_BIT1, 32'h0000_0007, 0, 0},
        '{0, IDX_CTRL1, 0, 0, 0},
        '{0, IDX_STAT, 0, 0, 0},
        '{0, 16'hff9a, 0, 0, 1}
    };

    // Clock line level from whichever side drives it
    assign sck_w = (sck_oe & sck_out) | (~sck_oe & sck_ext);

    sss_top sss_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .si_in(si),
        .so_out(so_out), .so_oe(so_oe), .timer_two(timer_two), .irq(irq)
    );
    sss_periph sss_periph_i [NCH-1:0] (
        .pclk(pclk), .sck(sck_w), .so(so_out), .si(si), .sck_ext(sck_ext),
        .load(load), .go(go), .tx(ptx), .rx(prx)
    );

    // Free-running clock
    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    // Timer output toggles every ten cycles
    always @(posedge pclk) begin
        tcnt <= (tcnt == 9) ? 0 : tcnt + 1;
        if (tcnt == 9) timer_two <= ~timer_two;
    end
    // Hang guard, well beyond the expected run
    initial begin
        #400000;
        num_errors++;
        $display("ERROR watchdog expected done seen hang");
        report_and_stop();
    end

    // APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
        int k = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Compare and count
    task automatic chk(input logic [31:0] e, input logic [31:0] g, input string w);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask
    // One table row
    task automatic row(input int i);
        apb(rows[i].wr, rows[i].idx, rows[i].d);
        chk(32'(rows[i].er), 32'(err), "error response");
        if (!rows[i].wr) chk(rows[i].e, rd, "read data");
    endtask
    // Full byte exchange on channel c with the partner
    task automatic xfer(input int c, input logic [7:0] ctrl, input logic [7:0] t,
                        input logic [7:0] p, input logic ien);
        logic [15:0] sh = c ? IDX_SHIFT2 : IDX_SHIFT1;
        logic [15:0] ci = c ? IDX_CTRL2 : IDX_CTRL1;
        int k = 0;
        apb(1, IDX_IEN, 32'(ien) << c);
        apb(1, ci, 32'(ctrl));
        @(posedge pclk);
        chk(32'({ctrl[1:0] != SEL_EXT, 1'b1}), 32'({sck_oe[c], so_oe[c]}), "pin drive");
        ptx[c] <= p;
        load[c] <= 1;
        @(posedge pclk) load[c] <= 0;
        apb(!ctrl[MODE_BIT], sh, 32'(t));
        if (ctrl[1:0] == SEL_EXT) begin
            go[c] <= 1;
            @(posedge pclk) go[c] <= 0;
        end
        do apb(0, IDX_STAT, 0); while (rd[c] !== 1'b1 && ++k < 150);
        chk(32'(ien), 32'(irq), "irq level");
        apb(1, ci, 32'(ctrl & 8'h7f));
        apb(0, sh, 0);
        chk(32'(p), rd, "received byte");
        chk(ctrl[MODE_BIT] ? 32'h0 : 32'(t), 32'(prx[c]), "sent byte");
        apb(1, IDX_ICLR, 32'h0000_0003);
        apb(0, IDX_STAT, 0);
        chk(32'h0, 32'({rd[1:0], irq}), "status clear");
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, timer_two, paddr, pwdata} = '0;
        {load, go, ptx, num_errors, tests_run, tcnt} = '0;
        pstrb = 4'hf;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk(32'h0000_0006, 32'({sck_oe, so_oe, sck_out, irq}), "reset pins");
        foreach (rows[i]) row(i);
        xfer(0, 8'h82, 8'ha5, 8'h3c, 1);
        xfer(1, 8'h83, 8'h5a, 8'hc3, 0);
        xfer(0, 8'h81, 8'h96, 8'h69, 1);
        xfer(1, 8'h80, 8'h81, 8'h7e, 1);
        xfer(0, 8'h86, 8'h00, 8'hb2, 1);
        xfer(1, 8'h84, 8'h00, 8'h4d, 0);
        // Data written while disabled must not start once enabled
        apb(1, IDX_SHIFT1, 32'h0000_00c3);
        apb(1, IDX_CTRL1, 32'h0000_0082);
        repeat (100) @(posedge pclk);
        apb(0, IDX_STAT, 0);
        chk(32'h0000_0003, 32'({rd[0], sck_out}), "no start");
        apb(1, IDX_CTRL1, 0);
        pstrb <= 4'he;
        apb(1, IDX_SHIFT1, 32'h0000_0011);
        chk(32'h0000_0001, 32'(err), "strobe refusal");
        pstrb <= 4'hf;
        apb(0, IDX_SHIFT1, 0);
        chk(32'h0000_00c3, rd, "shift kept");
        // Second reset in mid-run
        presetn <= 0;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) row(i);
        report_and_stop();
    end
endmodule
`default_nettype wire
